// [src/dcpw_top.sv]
// Serial slave front end of a 128-tap digital potentiometer with wiper and stored value.
// Assumes scl is the master's clock, used as a clock port; sda is open drain with external pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "dcpw_regs.svh"
module dcpw_top #(
  parameter int PU_CYCLES = `DCPW_PU_CYCLES,
  parameter int NVW_CYCLES = `DCPW_NVW_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_strap_pins,
  output logic [6:0] wiper_pos,
  output logic nv_busy
);
  // ---------------- Core domain ----------------
  logic scl_f;
  logic sda_f;
  logic [1:0] strap_f;
  logic scl_p_q;
  logic sda_p_q;
  logic start_ev;
  logic stop_ev;
  logic link_clr_q;
  logic link_go_q;
  logic [6:0] wiper_q;
  logic [6:0] stored_q;
  logic [7:0] select_q;
  logic [6:0] nv_data_q;
  logic nv_pend_q;
  logic nv_start_q;
  logic busy;
  logic recall;
  logic nv_done;
  logic wr_tog_f;
  logic wr_tog_p_q;
  logic wr_ev;
  dcpw_pkg::dcpw_snap_t snap_q;
  logic sda_out_q;

  // ---------------- Link domain ----------------
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] byte_d;
  logic [7:0] reg_addr_q;
  logic ack_q;
  dcpw_pkg::dcpw_phase_t phase_q;
  logic wr_tog_q;
  dcpw_pkg::dcpw_wr_t wr_q;
  logic [7:0] rd_byte;
  logic [2:0] rd_idx;
  logic sda_oe_q;

  dcpw_sync #(
    .WIDTH(4),
    .RST_VAL(4'hF)
  ) u_pin_sync (
    .clk(core_clk),
    .rst(rst),
    .din({scl, sda_in, addr_strap_pins}),
    .dout_q({scl_f, sda_f, strap_f})
  );

  dcpw_sync #(
    .WIDTH(1),
    .RST_VAL(1'h0)
  ) u_wr_sync (
    .clk(core_clk),
    .rst(rst),
    .din(wr_tog_q),
    .dout_q(wr_tog_f)
  );

  dcpw_nvm #(
    .PU_CYCLES(PU_CYCLES),
    .NVW_CYCLES(NVW_CYCLES)
  ) u_nvm (
    .clk(core_clk),
    .rst(rst),
    .nv_start(nv_start_q),
    .busy_q(busy),
    .recall_q(recall),
    .nv_done_q(nv_done)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      wr_tog_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      wr_tog_p_q <= wr_tog_f;
    end
  end

  assign start_ev = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_ev = scl_f & scl_p_q & ~sda_p_q & sda_f;
  assign wr_ev = wr_tog_f ^ wr_tog_p_q;

  // The link logic is held in reset outside frames. A START pulses the clear once so a
  // repeated START also restarts bit counting; the release falls one clock later, while the clock is still high after START.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      link_clr_q <= 1'b1;
      link_go_q <= 1'b0;
    end else if (start_ev && !busy) begin
      link_clr_q <= 1'b1;
      link_go_q <= 1'b1;
    end else if (start_ev || stop_ev || busy) begin
      link_clr_q <= 1'b1;
      link_go_q <= 1'b0;
    end else if (link_go_q) begin
      link_clr_q <= 1'b0;
      link_go_q <= 1'b0;
    end
  end

  // The snapshot only changes while the link is held, so the link reads stable words.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      snap_q <= '0;
    end else if (link_clr_q) begin
      snap_q <= '{wiper: wiper_q, stored: stored_q, select: select_q, strap: strap_f};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wiper_q <= `DCPW_WIPER_RST;
    end else if (recall) begin
      wiper_q <= stored_q;
    end else if (wr_ev && wr_q.addr == `DCPW_ADDR_WIPER) begin
      wiper_q <= wr_q.data[6:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      select_q <= `DCPW_SEL_NV;
    end else if (wr_ev && wr_q.addr == `DCPW_ADDR_SELECT) begin
      select_q <= wr_q.data;
    end
  end

  // A stored-value write is held until STOP, then the timed cycle commits it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_pend_q <= 1'b0;
      nv_data_q <= '0;
      nv_start_q <= 1'b0;
    end else begin
      nv_start_q <= 1'b0;
      if (wr_ev && wr_q.addr == `DCPW_ADDR_WIPER && select_q == `DCPW_SEL_NV) begin
        nv_pend_q <= 1'b1;
        nv_data_q <= wr_q.data[6:0];
      end else if (stop_ev && nv_pend_q && !busy) begin
        nv_pend_q <= 1'b0;
        nv_start_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stored_q <= `DCPW_STORED_RST;
    end else if (nv_done) begin
      stored_q <= nv_data_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wiper_pos <= `DCPW_WIPER_RST;
      nv_busy <= 1'b1;
      sda_out_q <= 1'b0;
    end else begin
      wiper_pos <= wiper_q;
      nv_busy <= busy;
      sda_out_q <= 1'b0;
    end
  end

  assign sda_out = sda_out_q;

  // ---------------- Link domain logic ----------------
  always_comb begin
    byte_d = {shift_q[6:0], sda_in};
    if (reg_addr_q == `DCPW_ADDR_WIPER) begin
      rd_byte = {1'b0, (snap_q.select == `DCPW_SEL_NV) ? snap_q.stored : snap_q.wiper};
    end else if (reg_addr_q == `DCPW_ADDR_SELECT) begin
      rd_byte = snap_q.select;
    end else begin
      rd_byte = 8'h00;
    end
    rd_idx = 3'h7 - bit_cnt_q[2:0];
  end

  always_ff @(posedge scl or posedge link_clr_q) begin
    if (link_clr_q) begin
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      ack_q <= 1'b0;
      phase_q <= dcpw_pkg::DCPW_PH_ID;
    end else if (bit_cnt_q != 4'h8) begin
      shift_q <= byte_d;
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q == 4'h7) begin
        unique case (phase_q)
          dcpw_pkg::DCPW_PH_ID: begin
            // Four strap combinations give four distinct addresses on one bus.
            if (byte_d[7:1] == {`DCPW_ID_PREFIX, snap_q.strap}) begin
              ack_q <= 1'b1;
              phase_q <= byte_d[0] ? dcpw_pkg::DCPW_PH_READ : dcpw_pkg::DCPW_PH_ADDR;
            end else begin
              phase_q <= dcpw_pkg::DCPW_PH_IGNORE;
            end
          end
          dcpw_pkg::DCPW_PH_ADDR: begin
            ack_q <= 1'b1;
            phase_q <= dcpw_pkg::DCPW_PH_WDATA;
          end
          dcpw_pkg::DCPW_PH_WDATA: begin
            ack_q <= 1'b1;
          end
          dcpw_pkg::DCPW_PH_READ: begin
            ack_q <= 1'b0;
          end
          dcpw_pkg::DCPW_PH_IGNORE: begin
            ack_q <= 1'b0;
          end
        endcase
      end
    end else begin
      bit_cnt_q <= 4'h0;
      ack_q <= 1'b0;
      if (phase_q == dcpw_pkg::DCPW_PH_READ && sda_in) begin
        phase_q <= dcpw_pkg::DCPW_PH_IGNORE;
      end
    end
  end

  // Register address survives a repeated START so a read can follow an address write.
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      reg_addr_q <= 8'h00;
    end else if (!link_clr_q && bit_cnt_q == 4'h7 && phase_q == dcpw_pkg::DCPW_PH_ADDR) begin
      reg_addr_q <= byte_d;
    end
  end

  // Write data stands held while the toggle crosses; it is not cleared between frames.
  always_ff @(posedge scl or posedge rst) begin
    if (rst) begin
      wr_tog_q <= 1'b0;
      wr_q <= '0;
    end else if (!link_clr_q && bit_cnt_q == 4'h7 && phase_q == dcpw_pkg::DCPW_PH_WDATA) begin
      wr_tog_q <= ~wr_tog_q;
      wr_q <= '{addr: reg_addr_q, data: byte_d};
    end
  end

  always_ff @(negedge scl or posedge link_clr_q) begin
    if (link_clr_q) begin
      sda_oe_q <= 1'b0;
    end else if (bit_cnt_q == 4'h8) begin
      sda_oe_q <= ack_q;
    end else begin
      sda_oe_q <= (phase_q == dcpw_pkg::DCPW_PH_READ) && !rd_byte[rd_idx];
    end
  end

  assign sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// [src/dcpw_regs.svh]
// Constants of the digital potentiometer serial slave: addresses, reset values, timing.
// Assumes a 10 MHz core clock; included by bare name wherever a constant is needed.
`ifndef DCPW_REGS_SVH
`define DCPW_REGS_SVH

`define DCPW_ID_PREFIX 5'h0A
`define DCPW_ADDR_WIPER 8'h00
`define DCPW_ADDR_SELECT 8'h02
`define DCPW_SEL_NV 8'h00
`define DCPW_SEL_VOL 8'h80
`define DCPW_WIPER_RST 7'h40
`define DCPW_STORED_RST 7'h40
`define DCPW_CLK_MHZ 10
`define DCPW_NVW_TYP_US 12000
`define DCPW_NVW_MAX_US 20000
`define DCPW_PU_DELAY_US 3000
`define DCPW_NVW_CYCLES (`DCPW_NVW_TYP_US * `DCPW_CLK_MHZ)
`define DCPW_PU_CYCLES (`DCPW_PU_DELAY_US * `DCPW_CLK_MHZ)

`endif

// [src/dcpw_pkg.sv]
// Types shared by the potentiometer serial slave modules.
// Assumes nothing beyond a SystemVerilog compiler.
package dcpw_pkg;

  typedef enum logic [2:0] {
    DCPW_PH_ID,
    DCPW_PH_ADDR,
    DCPW_PH_WDATA,
    DCPW_PH_READ,
    DCPW_PH_IGNORE
  } dcpw_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } dcpw_wr_t;

  typedef struct packed {
    logic [6:0] wiper;
    logic [6:0] stored;
    logic [7:0] select;
    logic [1:0] strap;
  } dcpw_snap_t;

endpackage

// [src/dcpw_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes inputs come from outside the clk domain; output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module dcpw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout_q
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Each bit follows only when its last two stages agree, filtering one-stage glitches.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout_q <= RST_VAL;
    end else begin
      dout_q <= (s2_q & ~(s2_q ^ s3_q)) | (dout_q & (s2_q ^ s3_q));
    end
  end
endmodule
`default_nettype wire

// [src/dcpw_nvm.sv]
// Power-up recall sequencer and self-timed non-volatile write timer.
// Assumes nv_start is a one-cycle pulse on clk and is only given while busy_q is low.
`timescale 1ns/1ps
`default_nettype none
`include "dcpw_regs.svh"
module dcpw_nvm #(
  parameter int PU_CYCLES = `DCPW_PU_CYCLES,
  parameter int NVW_CYCLES = `DCPW_NVW_CYCLES,
  parameter int CW = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic nv_start,
  output logic busy_q,
  output logic recall_q,
  output logic nv_done_q
);
  logic [CW-1:0] cnt_q;
  logic pu_q;
  logic wr_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      pu_q <= 1'b1;
      wr_q <= 1'b0;
      recall_q <= 1'b0;
      nv_done_q <= 1'b0;
    end else begin
      recall_q <= 1'b0;
      nv_done_q <= 1'b0;
      if (pu_q) begin
        if (cnt_q == CW'(PU_CYCLES - 1)) begin
          pu_q <= 1'b0;
          recall_q <= 1'b1;
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else if (wr_q) begin
        // The cycle ends at the typical time, well inside the 20 ms bound.
        if (cnt_q == CW'(NVW_CYCLES - 1)) begin
          wr_q <= 1'b0;
          nv_done_q <= 1'b1;
          cnt_q <= '0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else if (nv_start) begin
        wr_q <= 1'b1;
        cnt_q <= '0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b1;
    end else begin
      busy_q <= pu_q | wr_q | nv_start;
    end
  end
endmodule
`default_nettype wire

// [verification/dcpw_checker.sv]
// Concurrent checks on the top ports of the potentiometer serial slave.
// Assumes it is bound into dcpw_top with the two count parameters handed on.
`timescale 1ns/1ps
`default_nettype none
module dcpw_checker #(
  parameter int PU_CYCLES = 20,
  parameter int NVW_CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [1:0] addr_strap_pins,
  input wire logic [6:0] wiper_pos,
  input wire logic nv_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [31:0] busy_cnt_q;
  // One counter serves both timers, so the end of a stretch is judged against either length.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) busy_cnt_q <= '0;
    else if (nv_busy) busy_cnt_q <= busy_cnt_q + 32'h1;
    else busy_cnt_q <= '0;
  end
  chk_open_drain: assert property (sda_out == 1'b0)
    else $error("data output driven high");
  chk_wire_low: assert property (sda_oe |-> !sda_in)
    else $error("enabled data pin not low");
  chk_reset_state: assert property (disable iff (1'b0) rst |-> wiper_pos == 7'h40 && nv_busy && !sda_oe)
    else $error("outputs wrong in reset");
  chk_busy_length: assert property ($fell(nv_busy) |->
    (busy_cnt_q >= PU_CYCLES && busy_cnt_q <= PU_CYCLES + 4) ||
    (busy_cnt_q >= NVW_CYCLES - 1 && busy_cnt_q <= NVW_CYCLES + 4))
    else $error("busy stretch has wrong length");
  chk_wiper_frozen: assert property ($changed(wiper_pos) |-> ##[0:4] !nv_busy)
    else $error("wiper moved while busy");
  chk_busy_no_ack: assert property (nv_busy && $past(nv_busy, 3) |-> !sda_oe)
    else $error("data pin pulled while busy");
  chk_ack_idle: assert property ($rose(sda_oe) |-> !nv_busy && !$past(nv_busy))
    else $error("answer given while busy");
  chk_out_scl_high: assert property (scl [*5] |-> !$rose(sda_oe))
    else $error("data pin changed while clock high");
endmodule
`default_nettype wire

// [verification/dcpw_mstr.sv]
// Two-wire bus master model: makes the serial clock only within frames, 2.56 us a bit.
// Assumes the bench resolves the data wire from sda_low, the slave enable and a pull-up.
`timescale 1ns/1ps
`default_nettype none
module dcpw_mstr (
  output var logic scl,
  output var logic sda_low,
  input wire logic sda_w
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves only in the low half; the wire is read at the rise.
  // Both clock halves last over a microsecond because START and STOP are found by
  // sampling at 100 ns; a faster clock would make false START and STOP events.
  task automatic bit_io(input logic b, output logic r);
    #640 sda_low = !b;
    #704 scl = 1'b1;
    r = sda_w;
    #1216 scl = 1'b0;
  endtask
  task automatic start();
    #64 sda_low = 1'b0;
    #640 scl = 1'b1;
    #640 sda_low = 1'b1;
    #1216 scl = 1'b0;
  endtask
  task automatic stop();
    #640 sda_low = 1'b1;
    #704 scl = 1'b1;
    #640 sda_low = 1'b0;
    #1344;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
  // A single acknowledge probe: START, the identity byte, STOP; ack tells whether the slave answered.
  task automatic poll(input logic [7:0] id, output logic ack);
    start();
    wbyte(id, ack);
    stop();
  endtask
endmodule
`default_nettype wire

// [verification/i2c_wiper_register_slave_tb.sv]
// Bench for the potentiometer serial slave: one task per scenario, master model on the wire.
// Assumes the design, the checker and the master model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "dcpw_regs.svh"
module i2c_wiper_register_slave_tb;
  localparam int PU = 100;
  localparam int NVW = 50;
  logic core_clk = 1'b0;
  logic rst = 1'b0;
  logic [1:0] strap = 2'h0;
  logic scl, m_low, sda_oe, sda_out, nv_busy;
  logic [6:0] wiper_pos;
  int fails = 0;
  int n_tests = 0;
  // The pull-up wins unless some party pulls the wire low.
  wire logic sda_w = !(m_low || sda_oe);
  always #50 core_clk = !core_clk;
  dcpw_top #(.PU_CYCLES(PU), .NVW_CYCLES(NVW)) u_dcpw_top (.core_clk(core_clk), .rst(rst), .scl(scl),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pins(strap), .wiper_pos(wiper_pos),
    .nv_busy(nv_busy));
  dcpw_mstr u_dcpw_mstr (.scl(scl), .sda_low(m_low), .sda_w(sda_w));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [7:0] id(input logic rd);
    return {`DCPW_ID_PREFIX, strap, rd};
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    u_dcpw_mstr.start();
    u_dcpw_mstr.wbyte(id(1'b0), k0);
    u_dcpw_mstr.wbyte(a, k1);
    u_dcpw_mstr.wbyte(d, k2);
    u_dcpw_mstr.stop();
    check("write acks", {5'h00, k0, k1, k2}, 8'h07);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    logic k0, k1, k2;
    u_dcpw_mstr.start();
    u_dcpw_mstr.wbyte(id(1'b0), k0);
    u_dcpw_mstr.wbyte(a, k1);
    u_dcpw_mstr.start();
    u_dcpw_mstr.wbyte(id(1'b1), k2);
    u_dcpw_mstr.rbyte(1'b1, d);
    u_dcpw_mstr.stop();
    check("read acks", {5'h00, k0, k1, k2}, 8'h07);
  endtask
  task automatic wait_idle(input int lim);
    for (int i = 0; i < lim && nv_busy !== 1'b0; i++) @(negedge core_clk);
    check("busy end", {7'h00, nv_busy}, 8'h00);
  endtask
  task automatic t_powerup();
    logic ack;
    check("wiper reset", {1'b0, wiper_pos}, {1'b0, `DCPW_WIPER_RST});
    u_dcpw_mstr.poll(id(1'b0), ack);
    check("ack powering", {7'h00, ack}, 8'h00);
    wait_idle(PU + 10);
    check("wiper recall", {1'b0, wiper_pos}, {1'b0, `DCPW_STORED_RST});
  endtask
  task automatic t_strap();
    logic ack;
    for (int s = 0; s < 4; s++) begin
      @(negedge core_clk);
      strap = 2'(s);
      repeat (6) @(negedge core_clk);
      for (int a = 0; a < 4; a++) begin
        u_dcpw_mstr.poll({`DCPW_ID_PREFIX, 2'(a), 1'b0}, ack);
        check("strap match", {7'h00, ack}, {7'h00, a == s});
      end
    end
  endtask
  task automatic t_volatile();
    logic [7:0] d;
    wr_reg(`DCPW_ADDR_SELECT, `DCPW_SEL_VOL);
    wr_reg(`DCPW_ADDR_WIPER, 8'h7F);
    check("wiper high", {1'b0, wiper_pos}, 8'h7F);
    check("no nv cycle", {7'h00, nv_busy}, 8'h00);
    rd_reg(`DCPW_ADDR_WIPER, d);
    check("read wiper", d, 8'h7F);
    wr_reg(`DCPW_ADDR_WIPER, 8'h00);
    check("wiper low", {1'b0, wiper_pos}, 8'h00);
    wr_reg(`DCPW_ADDR_SELECT, `DCPW_SEL_NV);
    rd_reg(`DCPW_ADDR_WIPER, d);
    check("read stored", d, {1'b0, `DCPW_STORED_RST});
  endtask
  task automatic t_nonvolatile();
    logic [7:0] d;
    logic ack;
    wr_reg(`DCPW_ADDR_WIPER, 8'h55);
    check("wiper follows", {1'b0, wiper_pos}, 8'h55);
    check("nv cycle", {7'h00, nv_busy}, 8'h01);
    u_dcpw_mstr.poll(id(1'b0), ack);
    check("ack writing", {7'h00, ack}, 8'h00);
    wait_idle(NVW * 20 / 12);
    rd_reg(`DCPW_ADDR_WIPER, d);
    check("stored kept", d, 8'h55);
  endtask
  // Reset rises before the first clock edge so the checker never samples unreset flops.
  initial begin
    #1 rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    t_powerup();
    t_strap();
    t_volatile();
    t_nonvolatile();
    end_sim();
  end
  initial begin
    #3000000;
    fails++;
    end_sim();
  end
endmodule
bind dcpw_top dcpw_checker #(.PU_CYCLES(PU_CYCLES), .NVW_CYCLES(NVW_CYCLES)) u_dcpw_checker (.core_clk(core_clk),
  .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pins(addr_strap_pins),
  .wiper_pos(wiper_pos), .nv_busy(nv_busy));
`default_nettype wire
